/* core/esf_pkg.sv */
// package of constants and types for the encapsulated sentence framer
package esf_pkg;
  // framing characters
  localparam logic [7:0] CH_ENCAP = 8'h21;
  localparam logic [7:0] CH_QUERY = 8'h24;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_LETTER_A = 8'h41;
  // six-bit armouring offsets
  localparam logic [7:0] ARM_LOW_OFS = 8'h30;
  localparam logic [7:0] ARM_HIGH_OFS = 8'h38;
  localparam logic [5:0] ARM_SPLIT = 6'h28;
  localparam int SIXBIT_W = 6;
  localparam logic [2:0] PAD_MAX = 3'h5;
  // default field widths and sequence id limit
  localparam int SEQ_MAX_DEF = 9;
  localparam int MAX_CHARS_DEF = 64;

  // transmit sequencer states
  typedef enum logic [3:0] {
    ESF_IDLE = 4'h0,
    ESF_START = 4'h1,
    ESF_ADDR = 4'h2,
    ESF_TOTAL = 4'h3,
    ESF_INDEX = 4'h4,
    ESF_SEQ = 4'h5,
    ESF_PAYLOAD = 4'h6,
    ESF_PAD = 4'h7,
    ESF_STAR = 4'h8,
    ESF_HI = 4'h9,
    ESF_LO = 4'ha,
    ESF_CR = 4'hb,
    ESF_LF = 4'hc,
    ESF_QFMT = 4'hd
  } esf_tx_state_t;

  // receive checker states
  typedef enum logic [2:0] {
    ESF_R_HUNT = 3'h0,
    ESF_R_BODY = 3'h1,
    ESF_R_HI = 3'h2,
    ESF_R_LO = 3'h3,
    ESF_R_CR = 3'h4,
    ESF_R_LF = 3'h5
  } esf_rx_state_t;

  // nibble to upper-case hex character
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'ha) begin
      hex_char = CH_ZERO + {4'h0, n};
    end else begin
      hex_char = CH_LETTER_A + {4'h0, n - 4'ha};
    end
  endfunction

  // hex character to nibble, bit 4 flags an illegal character
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= CH_ZERO && c <= 8'h39) begin
      hex_val = {1'b0, c[3:0]};
    end else if (c >= CH_LETTER_A && c <= 8'h46) begin
      hex_val = {1'b0, c[3:0] + 4'h9};
    end else begin
      hex_val = 5'h10;
    end
  endfunction

  // decimal digit character
  function automatic logic [7:0] dec_char(input logic [3:0] d);
    dec_char = CH_ZERO + {4'h0, d};
  endfunction
endpackage

/* core/esf_chk_if.sv */
// interface carrying receive bytes and checker verdicts
`timescale 1ns/10ps
interface esf_chk_if;
  logic rx_valid;
  logic [7:0] rx_data;
  logic good;
  logic bad;
  modport checker_end (input rx_valid, input rx_data, output good,
    output bad);
  modport framer_end (output rx_valid, output rx_data, input good,
    input bad);
endinterface

/* core/esf_rx_check.sv */
// receive sentence checksum checker
`timescale 1ns/10ps
module esf_rx_check (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // byte stream and verdicts
  esf_chk_if.checker_end chk
);
  esf_pkg::esf_rx_state_t state_q;
  logic [7:0] sum_q;
  logic [3:0] hi_q;
  logic mism_q;
  logic [4:0] hv;

  assign hv = esf_pkg::hex_val(chk.rx_data);

  // checksum state machine, running xor and verdict pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= esf_pkg::ESF_R_HUNT;
      sum_q <= 8'h00;
      hi_q <= 4'h0;
      mism_q <= 1'b0;
      chk.good <= 1'b0;
      chk.bad <= 1'b0;
    end else begin
      chk.good <= 1'b0;
      chk.bad <= 1'b0;
      if (chk.rx_valid) begin
        if (chk.rx_data == esf_pkg::CH_ENCAP ||
            chk.rx_data == esf_pkg::CH_QUERY) begin
          state_q <= esf_pkg::ESF_R_BODY;
          sum_q <= 8'h00;
          mism_q <= 1'b0;
        end else begin
          unique case (state_q)
            esf_pkg::ESF_R_HUNT: begin
            end
            esf_pkg::ESF_R_BODY: begin
              if (chk.rx_data == esf_pkg::CH_STAR) begin
                state_q <= esf_pkg::ESF_R_HI;
              end else begin
                sum_q <= sum_q ^ chk.rx_data;
              end
            end
            esf_pkg::ESF_R_HI: begin
              hi_q <= hv[3:0];
              mism_q <= hv[4];
              state_q <= esf_pkg::ESF_R_LO;
            end
            esf_pkg::ESF_R_LO: begin
              mism_q <= mism_q | hv[4] | ({hi_q, hv[3:0]} != sum_q);
              state_q <= esf_pkg::ESF_R_CR;
            end
            esf_pkg::ESF_R_CR: begin
              if (chk.rx_data == esf_pkg::CH_CR) begin
                state_q <= esf_pkg::ESF_R_LF;
              end else begin
                chk.bad <= 1'b1;
                state_q <= esf_pkg::ESF_R_HUNT;
              end
            end
            esf_pkg::ESF_R_LF: begin
              chk.good <= (chk.rx_data == esf_pkg::CH_LF) & ~mism_q;
              chk.bad <= (chk.rx_data != esf_pkg::CH_LF) | mism_q;
              state_q <= esf_pkg::ESF_R_HUNT;
            end
            default: state_q <= esf_pkg::ESF_R_HUNT;
          endcase
        end
      end
    end
  end
endmodule // esf_rx_check

/* core/esf_framer.sv */
// encapsulation and query sentence framer with receive checker
`timescale 1ns/10ps
module esf_framer #(
  parameter int SEQ_MAX = esf_pkg::SEQ_MAX_DEF,
  parameter int MAX_CHARS = esf_pkg::MAX_CHARS_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // message request from the application
  input wire logic msg_start_i,
  input wire logic query_i,
  input wire logic [15:0] talker_i,
  input wire logic [23:0] formatter_i,
  input wire logic [15:0] peer_talker_i,
  input wire logic [3:0] sentence_total_count_i,
  input wire logic [3:0] sentence_index_i,
  input wire logic new_message_i,
  input wire logic [7:0] payload_bits_i,
  output logic busy_o,
  output logic done_o,
  output logic [3:0] message_sequence_id_o,
  // payload supply, six bits at a time
  output logic sym_req_o,
  input wire logic [5:0] sym_i,
  // transmit byte stream
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // receive byte stream and verdicts
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_good_o,
  output logic rx_error_o
);
  esf_pkg::esf_tx_state_t state_q;
  logic [2:0] cnt_q;
  logic [7:0] sym_left_q;
  logic [7:0] sum_q;
  logic [2:0] pad_q;
  logic [15:0] talker_q;
  logic [23:0] fmt_q;
  logic [15:0] peer_q;
  logic [3:0] total_q;
  logic [3:0] index_q;
  logic query_q;
  logic new_q;
  logic [7:0] ch;
  logic adv;
  logic last_addr;
  logic [7:0] nsym;
  logic [2:0] rem;
  esf_chk_if chk ();

  // armour a six-bit value into its payload character
  function automatic logic [7:0] armour(input logic [5:0] v);
    if (v < esf_pkg::ARM_SPLIT) begin
      armour = {2'b00, v} + esf_pkg::ARM_LOW_OFS;
    end else begin
      armour = {2'b00, v} + esf_pkg::ARM_HIGH_OFS;
    end
  endfunction

  // payload symbol count and padding from the bit count
  always_comb begin
    rem = 3'(payload_bits_i % esf_pkg::SIXBIT_W);
    nsym = 8'(payload_bits_i / esf_pkg::SIXBIT_W) + {7'h00, rem != 3'h0};
  end

  // output character for the current position
  always_comb begin
    ch = esf_pkg::CH_COMMA;
    last_addr = 1'b0;
    unique case (state_q)
      esf_pkg::ESF_IDLE: ch = 8'h00;
      esf_pkg::ESF_START: begin
        ch = query_q ? esf_pkg::CH_QUERY : esf_pkg::CH_ENCAP;
      end
      esf_pkg::ESF_ADDR: begin
        if (query_q) begin
          last_addr = cnt_q == 3'h4;
          unique case (cnt_q)
            3'h0: ch = talker_q[15:8];
            3'h1: ch = talker_q[7:0];
            3'h2: ch = peer_q[15:8];
            3'h3: ch = peer_q[7:0];
            default: ch = esf_pkg::CH_Q;
          endcase
        end else begin
          last_addr = cnt_q == 3'h4;
          unique case (cnt_q)
            3'h0: ch = talker_q[15:8];
            3'h1: ch = talker_q[7:0];
            3'h2: ch = fmt_q[23:16];
            3'h3: ch = fmt_q[15:8];
            default: ch = fmt_q[7:0];
          endcase
        end
      end
      esf_pkg::ESF_TOTAL: begin
        ch = cnt_q == 3'h0 ? esf_pkg::CH_COMMA :
          esf_pkg::dec_char(total_q);
      end
      esf_pkg::ESF_INDEX: begin
        ch = cnt_q == 3'h0 ? esf_pkg::CH_COMMA :
          esf_pkg::dec_char(index_q);
      end
      esf_pkg::ESF_SEQ: begin
        ch = cnt_q == 3'h0 ? esf_pkg::CH_COMMA :
          esf_pkg::dec_char(message_sequence_id_o);
      end
      esf_pkg::ESF_PAYLOAD: begin
        ch = cnt_q == 3'h0 ? esf_pkg::CH_COMMA : armour(sym_i);
      end
      esf_pkg::ESF_PAD: begin
        ch = cnt_q == 3'h0 ? esf_pkg::CH_COMMA :
          esf_pkg::dec_char({1'b0, pad_q});
      end
      esf_pkg::ESF_QFMT: begin
        unique case (cnt_q)
          3'h0: ch = esf_pkg::CH_COMMA;
          3'h1: ch = fmt_q[23:16];
          3'h2: ch = fmt_q[15:8];
          default: ch = fmt_q[7:0];
        endcase
      end
      esf_pkg::ESF_STAR: ch = esf_pkg::CH_STAR;
      esf_pkg::ESF_HI: ch = esf_pkg::hex_char(sum_q[7:4]);
      esf_pkg::ESF_LO: ch = esf_pkg::hex_char(sum_q[3:0]);
      esf_pkg::ESF_CR: ch = esf_pkg::CH_CR;
      esf_pkg::ESF_LF: ch = esf_pkg::CH_LF;
      default: ch = 8'h00;
    endcase
  end

  // a character moves when the output stage is free or accepted
  assign adv = state_q != esf_pkg::ESF_IDLE && (!tx_valid_o || tx_ready_i);

  // capture request fields at sentence start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      talker_q <= 16'h0000;
      fmt_q <= 24'h000000;
      peer_q <= 16'h0000;
      total_q <= 4'h0;
      index_q <= 4'h0;
      query_q <= 1'b0;
      new_q <= 1'b0;
    end else if (state_q == esf_pkg::ESF_IDLE && msg_start_i) begin
      talker_q <= talker_i;
      fmt_q <= formatter_i;
      peer_q <= peer_talker_i;
      total_q <= sentence_total_count_i;
      index_q <= sentence_index_i;
      query_q <= query_i;
      new_q <= new_message_i & ~query_i;
    end
  end

  // sequence id: bump on each new encapsulated message, wrap past max
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      message_sequence_id_o <= 4'h0;
    end else if (state_q == esf_pkg::ESF_START && adv && new_q) begin
      if (message_sequence_id_o >= 4'(SEQ_MAX)) begin
        message_sequence_id_o <= 4'h0;
      end else begin
        message_sequence_id_o <= message_sequence_id_o + 4'h1;
      end
    end
  end

  // sentence sequencer, position counter and running checksum
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= esf_pkg::ESF_IDLE;
      cnt_q <= 3'h0;
      sym_left_q <= 8'h00;
      pad_q <= 3'h0;
      sum_q <= 8'h00;
    end else if (state_q == esf_pkg::ESF_IDLE) begin
      if (msg_start_i) begin
        state_q <= esf_pkg::ESF_START;
        cnt_q <= 3'h0;
        sum_q <= 8'h00;
        sym_left_q <= nsym;
        pad_q <= rem == 3'h0 ? 3'h0 :
          3'(esf_pkg::SIXBIT_W) - rem;
      end
    end else if (adv) begin
      if (state_q != esf_pkg::ESF_START && state_q < esf_pkg::ESF_STAR ||
          state_q == esf_pkg::ESF_QFMT) begin
        sum_q <= sum_q ^ ch;
      end
      cnt_q <= cnt_q + 3'h1;
      unique case (state_q)
        esf_pkg::ESF_START: begin
          state_q <= esf_pkg::ESF_ADDR;
          cnt_q <= 3'h0;
        end
        esf_pkg::ESF_ADDR: begin
          if (last_addr) begin
            state_q <= query_q ? esf_pkg::ESF_QFMT : esf_pkg::ESF_TOTAL;
            cnt_q <= 3'h0;
          end
        end
        esf_pkg::ESF_TOTAL, esf_pkg::ESF_INDEX, esf_pkg::ESF_SEQ,
        esf_pkg::ESF_PAD: begin
          if (cnt_q == 3'h1) begin
            state_q <= state_q == esf_pkg::ESF_PAD ? esf_pkg::ESF_STAR :
              esf_tx_next(state_q);
            cnt_q <= 3'h0;
          end
        end
        esf_pkg::ESF_PAYLOAD: begin
          cnt_q <= 3'h1;
          if (cnt_q != 3'h0) begin
            sym_left_q <= sym_left_q - 8'h01;
          end
          if (cnt_q != 3'h0 && sym_left_q <= 8'h01 ||
              cnt_q == 3'h0 && sym_left_q == 8'h00) begin
            state_q <= esf_pkg::ESF_PAD;
            cnt_q <= 3'h0;
          end
        end
        esf_pkg::ESF_QFMT: begin
          if (cnt_q == 3'h3) begin
            state_q <= esf_pkg::ESF_STAR;
          end
        end
        esf_pkg::ESF_STAR: state_q <= esf_pkg::ESF_HI;
        esf_pkg::ESF_HI: state_q <= esf_pkg::ESF_LO;
        esf_pkg::ESF_LO: state_q <= esf_pkg::ESF_CR;
        esf_pkg::ESF_CR: state_q <= esf_pkg::ESF_LF;
        esf_pkg::ESF_LF: state_q <= esf_pkg::ESF_IDLE;
        default: state_q <= esf_pkg::ESF_IDLE;
      endcase
    end
  end

  // next field after the current numeric one
  function automatic esf_pkg::esf_tx_state_t esf_tx_next(
    input esf_pkg::esf_tx_state_t s);
    unique case (s)
      esf_pkg::ESF_TOTAL: esf_tx_next = esf_pkg::ESF_INDEX;
      esf_pkg::ESF_INDEX: esf_tx_next = esf_pkg::ESF_SEQ;
      default: esf_tx_next = esf_pkg::ESF_PAYLOAD;
    endcase
  endfunction

  // output register stage for the talker byte stream
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      sym_req_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      sym_req_o <= 1'b0;
      done_o <= 1'b0;
      if (adv) begin
        tx_valid_o <= 1'b1;
        tx_data_o <= ch;
        sym_req_o <= state_q == esf_pkg::ESF_PAYLOAD && cnt_q != 3'h0;
        done_o <= state_q == esf_pkg::ESF_LF;
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  // busy flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= state_q != esf_pkg::ESF_IDLE || msg_start_i;
    end
  end

  // receive path: byte stream into the checker for its verdicts
  assign chk.rx_valid = rx_valid_i;
  assign chk.rx_data = rx_data_i;

  esf_rx_check u_rx_check (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .chk(chk)
  );

  // registered verdicts, the query reply is never waited on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_good_o <= 1'b0;
      rx_error_o <= 1'b0;
    end else begin
      rx_good_o <= chk.good;
      rx_error_o <= chk.bad;
    end
  end
endmodule // esf_framer

/* tb/esf_framer_checker.sv */
// port assertions for the sentence framer
`timescale 1ns/10ps
module esf_framer_checker #(
  parameter int SEQ_MAX = 9
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request side
  input wire logic msg_start_i,
  input wire logic query_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [3:0] message_sequence_id_o,
  // byte streams
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_good_o,
  input wire logic rx_error_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  logic in_ck_q;
  logic encap_q;
  logic [7:0] sum_q;
  logic [7:0] last_q;
  logic [7:0] last2_q;
  // upper-case hex character of a nibble
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  assign acc = tx_valid_o && tx_ready_i;
  // running xor of accepted bytes and the last two accepted bytes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_q <= 8'h00;
      last_q <= 8'h00;
      last2_q <= 8'h00;
      in_ck_q <= 1'b0;
      encap_q <= 1'b0;
    end else if (acc) begin
      last_q <= tx_data_o;
      last2_q <= last_q;
      if (tx_data_o == 8'h21 || tx_data_o == 8'h24) begin
        sum_q <= 8'h00;
        in_ck_q <= 1'b0;
        encap_q <= (tx_data_o == 8'h21);
      end else if (tx_data_o == 8'h2a) begin
        in_ck_q <= 1'b1;
      end else if (!in_ck_q) begin
        sum_q <= sum_q ^ tx_data_o;
      end
    end
  end
  a_encap_start: assert property (msg_start_i && !busy_o && !query_i |->
    ##2 tx_valid_o && tx_data_o == 8'h21) else $error("bad encap start");
  a_query_start: assert property (msg_start_i && !busy_o && query_i |->
    ##2 tx_valid_o && tx_data_o == 8'h24) else $error("bad query start");
  a_ck_high: assert property (acc && in_ck_q && last_q == 8'h2a |->
    tx_data_o == hexc(sum_q[7:4])) else $error("bad checksum high char");
  a_ck_low: assert property (acc && in_ck_q && last2_q == 8'h2a |->
    tx_data_o == hexc(sum_q[3:0])) else $error("bad checksum low char");
  a_cr_then_lf: assert property (acc && last_q == 8'h0d |->
    tx_data_o == 8'h0a) else $error("line feed missing");
  a_done_on_lf: assert property ($rose(done_o) |-> tx_valid_o &&
    tx_data_o == 8'h0a && last_q == 8'h0d) else $error("done off lf");
  a_pad_field_last: assert property (acc && encap_q &&
    tx_data_o == 8'h2a |-> last2_q == 8'h2c &&
    last_q inside {[8'h30:8'h35]}) else $error("bad pad field");
  a_seq_id_step: assert property ($changed(message_sequence_id_o) |->
    message_sequence_id_o == (($past(message_sequence_id_o) == SEQ_MAX) ?
    4'h0 : $past(message_sequence_id_o) + 4'h1)) else $error("bad seq step");
  a_rx_good_time: assert property (rx_good_o |->
    $past(rx_valid_i && rx_data_i == 8'h0a, 2)) else $error("good off lf");
  a_rx_one_verdict: assert property (!(rx_good_o && rx_error_o))
    else $error("two verdicts");
endmodule // esf_framer_checker

bind esf_framer esf_framer_checker #(.SEQ_MAX(SEQ_MAX)) i_esf_framer_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .msg_start_i(msg_start_i),
  .query_i(query_i), .busy_o(busy_o), .done_o(done_o),
  .message_sequence_id_o(message_sequence_id_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
  .rx_data_i(rx_data_i), .rx_good_o(rx_good_o), .rx_error_o(rx_error_o));

/* tb/esf_bus_peer.sv */
// listener and talker instruments on the far side of the framer
`timescale 1ns/10ps
module esf_bus_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // stall control
  input wire logic slow_i,
  // framer transmit stream
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o = 1'b0,
  // talker stream into the framer
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_data_o = 8'h00
);
  logic [7:0] got[$];
  logic [1:0] tick = 2'h0;
  // listener takes bytes, one cycle in four when slow; never answers a query
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    #1;
    tick = tick + 2'h1;
    tx_ready_o = rst_n_i && (!slow_i || tick == 2'h0);
  end
  // talker sends one byte a cycle, then drops valid and inverts the data once
  task automatic say(input string s);
    foreach (s[i]) begin
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_data_o = s[i];
    end
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule // esf_bus_peer

/* tb/esf_framer_bench.sv */
// self-checking bench for the sentence framer
`timescale 1ns/10ps
module esf_framer_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic msg_start_i = 1'b0;
  logic query_i = 1'b0;
  logic new_message_i = 1'b0;
  logic slow = 1'b0;
  logic [15:0] talker_i = 16'h4149;
  logic [15:0] peer_talker_i = 16'h4750;
  logic [23:0] formatter_i = 24'h56444d;
  logic [3:0] tot = 4'h1;
  logic [3:0] idx = 4'h1;
  logic [7:0] bits = 8'h00;
  logic [5:0] syms [0:1] = '{6'h05, 6'h2c};
  logic busy_o, done_o, sym_req_o, tx_valid_o, tx_ready_i;
  logic rx_valid_i, rx_good_o, rx_error_o;
  logic [3:0] seq_id;
  logic [5:0] sym_i;
  logic [7:0] tx_data_o, rx_data_i;
  int sp = 0;
  int err_count = 0;
  int check_count = 0;
  int good_n = 0;
  int bad_n = 0;

  esf_framer i_esf_framer (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .msg_start_i(msg_start_i), .query_i(query_i), .talker_i(talker_i),
    .formatter_i(formatter_i), .peer_talker_i(peer_talker_i),
    .sentence_total_count_i(tot), .sentence_index_i(idx),
    .new_message_i(new_message_i), .payload_bits_i(bits), .busy_o(busy_o),
    .done_o(done_o), .message_sequence_id_o(seq_id), .sym_req_o(sym_req_o),
    .sym_i(sym_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_good_o(rx_good_o), .rx_error_o(rx_error_o));
  esf_bus_peer i_esf_bus_peer (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

  // clock and payload supply, next symbol after each consume pulse
  always #4 clk_i = ~clk_i;
  assign sym_i = syms[sp];
  always @(posedge clk_i) begin
    #1;
    if (rx_good_o === 1'b1) good_n++;
    if (rx_error_o === 1'b1) bad_n++;
    if (sym_req_o === 1'b1) sp++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  // whole sentence with checksum and terminator
  function automatic string frame(input logic [7:0] st, input string b);
    logic [7:0] ck;
    ck = 8'h00;
    foreach (b[i]) ck = ck ^ b[i];
    return $sformatf("%c%s*%c%c%c%c", st, b, hx(ck[7:4]), hx(ck[3:0]),
      8'h0d, 8'h0a);
  endfunction
  // start one sentence, wait for it to finish and compare every byte
  task automatic send(input logic q, input logic [3:0] t, input logic [3:0] x,
    input logic nm, input logic [7:0] b, input string e);
    int n;
    i_esf_bus_peer.got.delete();
    sp = 0;
    query_i = q;
    tot = t;
    idx = x;
    new_message_i = nm;
    bits = b;
    msg_start_i = 1'b1;
    @(posedge clk_i);
    #1;
    msg_start_i = 1'b0;
    // wait until the sentence is done and its line feed was taken
    for (n = 0; n < 3000 && (busy_o !== 1'b0 || tx_valid_o !== 1'b0);
      n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n >= 3000) err_count++;
    check(8'(i_esf_bus_peer.got.size()), 8'(e.len()));
    foreach (e[i]) check(i_esf_bus_peer.got[i], e[i]);
  endtask

  task automatic test_encap;
    slow = 1'b1;
    send(0, 4'h2, 4'h1, 1, 8'h08,
      frame(8'h21, "AIVDM,2,1,1,5d,4"));
    send(0, 4'h2, 4'h2, 0, 8'h06,
      frame(8'h21, "AIVDM,2,2,1,5,0"));
    check(8'(seq_id), 8'h01);
    $display("test encap done");
  endtask
  task automatic test_wrap;
    slow = 1'b0;
    for (int k = 2; k <= 10; k++) begin
      send(0, 4'h1, 4'h1, 1, 8'h00,
        frame(8'h21, $sformatf("AIVDM,1,1,%0d,,0", k % 10)));
      check(8'(seq_id), 8'(k % 10));
    end
    $display("test wrap done");
  endtask
  task automatic test_query;
    formatter_i = 24'h524d43;
    send(1, 4'h1, 4'h1, 0, 8'h00,
      frame(8'h24, "AIGPQ,RMC"));
    $display("test query done");
  endtask
  task automatic test_rx;
    string s;
    int g;
    int e;
    g = good_n;
    e = bad_n;
    i_esf_bus_peer.say(frame(8'h21, "AIVDM,1,1,0,5,0"));
    s = frame(8'h24, "GPRMC,1");
    s[s.len() - 3] = (s[s.len() - 3] == 8'h30) ? 8'h31 : 8'h30;
    i_esf_bus_peer.say(s);
    repeat (4) @(posedge clk_i);
    #1;
    check(8'(good_n - g), 8'h01);
    check(8'(bad_n - e), 8'h01);
    $display("test rx done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    test_encap();
    test_wrap();
    test_query();
    test_rx();
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule // esf_framer_bench
